// [include/wdpg_pkg.sv]
// shared constants, types and register map of the watchdog / power-good block
package wdpg_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;                 // 100 MHz system clock
  localparam int SHARE_PERIOD_US = 10;               // own shared-clock period
  localparam int SHARE_PERIOD_CYC = SHARE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int SHARE_HALF_CYC = SHARE_PERIOD_CYC / 2;  // low time we drive
  localparam int DEGLITCH_US = 20;                   // held-low deglitch time
  localparam int DEGLITCH_CYC = DEGLITCH_US * 1000 / CLK_PERIOD_NS;
  localparam int PRESENT_CYC = DEGLITCH_CYC;         // no falling edge -> absent
  localparam int WD_TICK_US = 10;                    // watchdog base tick
  localparam int WD_TICK_CYC = WD_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int PG_STEP_US = 200;                   // assertion delay step
  localparam int PG_STEP_TICKS = PG_STEP_US / SHARE_PERIOD_US;
  localparam int FIRST_STEP_US = 1000;               // first interval step
  localparam int FIRST_TICKS = FIRST_STEP_US / WD_TICK_US;
  // ==========================================================
  // l11 scale and clamp per register (steps per ms, max steps)
  localparam int PG_SCALE = 1000 / PG_STEP_US;       // 200 us steps
  localparam int PG_MAX_STEPS = 65500;               // 13.1 s
  localparam int FIRST_SCALE = 1000 / FIRST_STEP_US; // 1 ms steps
  localparam int FIRST_MAX_STEPS = 65000;            // 65 s
  localparam int NEXT_SCALE = 1000 / WD_TICK_US;     // 10 us steps
  localparam int NEXT_MAX_STEPS = 65500;             // 655 ms
  // ==========================================================
  // register map (command codes) and reset values
  localparam logic [7:0] CMD_PG_SOURCE = 8'hd4;     // power_good_source_select
  localparam logic [7:0] CMD_PG_DELAY = 8'he1;      // power_good_assert_delay
  localparam logic [7:0] CMD_WD_FIRST = 8'he2;      // first_kick_interval
  localparam logic [7:0] CMD_WD_NEXT = 8'he3;       // kick_interval
  localparam logic [15:0] RST_PG_SOURCE = 16'h0000;
  localparam logic [15:0] RST_PG_DELAY = 16'heb20;  // 100 ms
  localparam logic [15:0] RST_WD_INTERVAL = 16'h8000; // 0 ms
  localparam logic [15:0] PG_SOURCE_MASK = 16'h010f; // writable bits
  localparam int PG_SRC_WDOG_BIT = 8;                // watchdog gating bit
  localparam int NUM_CHAN = 4;
  localparam int L11_MAN_MSB = 10;                   // mantissa top bit
  // ==========================================================
  // command port carrier
  typedef struct packed {
    logic wr;           // write strobe
    logic rd;           // read strobe
    logic [7:0] code;   // command code
    logic [15:0] wdata; // write word
  } wdpg_cmd_s;
endpackage

// [core/wdpg_l11_steps.sv]
// converts an l11 millisecond word into clamped, rounded step counts
`timescale 1ns/100ps
module wdpg_l11_steps
  import wdpg_pkg::*;
#(
  parameter int SCALE = 1,       // steps per millisecond
  parameter int MAX_STEPS = 1    // clamp
) (
  input wire logic [15:0] l11_i,   // raw register word
  output logic [15:0] steps_o      // effective step count
);
  // ==========================================================
  // field split
  wire signed [4:0] exp_s = l11_i[15:11];           // signed exponent
  wire man_neg = l11_i[L11_MAN_MSB];                // negative mantissa
  wire [47:0] prod = man_neg ? 48'h0 : 48'(l11_i[9:0]) * 48'(SCALE);
  wire [47:0] max_w = 48'(MAX_STEPS);
  // ==========================================================
  // shift, round to nearest, clamp
  logic [47:0] shifted;  // scaled value before clamp
  logic [4:0] k;         // right shift amount
  always_comb begin
    k = 5'h0;
    shifted = 48'h0;
    if (!exp_s[4]) begin
      shifted = prod << exp_s;
    end else begin
      k = 5'(-exp_s);
      shifted = (prod + (48'h1 << (k - 5'h1))) >> k;
    end
    if (shifted > max_w) begin
      steps_o = 16'(MAX_STEPS);
    end else begin
      steps_o = shifted[15:0];
    end
  end
endmodule

// [core/wdpg_share_clk.sv]
// open-drain shared clock: drive, resync, presence, input-voltage sharing
`timescale 1ns/100ps
module wdpg_share_clk
  import wdpg_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic share_clk_i,   // resolved line level
  input wire logic vin_share_i,   // input voltage sharing enabled
  input wire logic vin_ok_i,      // own input voltage adequate
  output logic share_clk_oe_o,    // pull line low
  output logic base_tick_o,       // time base: line fall or internal
  output logic chan_off_o,        // pulse: disable all channels
  output logic start_seq_o        // pulse: begin start sequence
);
  // ==========================================================
  // state
  logic line_q;              // previous line level
  logic [15:0] div_cnt;      // own clock divider
  logic [15:0] gap_cnt;      // cycles since last falling edge
  logic [15:0] low_cnt;      // cycles the line has been low
  logic held;                // line seen held low
  wire line_fall = line_q & ~share_clk_i;
  wire div_wrap = div_cnt == 16'(SHARE_PERIOD_CYC - 1);
  wire present = gap_cnt < 16'(PRESENT_CYC);
  wire own_low = div_cnt < 16'(SHARE_HALF_CYC);
  wire vin_hold = vin_share_i & ~vin_ok_i;
  wire held_now = vin_share_i & ~share_clk_i & (low_cnt == 16'(DEGLITCH_CYC - 1));
  // ==========================================================
  // divider resyncs to fastest falling edge on the line
  always_ff @(posedge clock_i) begin
    if (rst_i || line_fall || div_wrap) begin
      div_cnt <= 16'h0;
    end else begin
      div_cnt <= div_cnt + 16'h1;
    end
  end
  // ==========================================================
  // line monitors
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      line_q <= 1'b1;
      gap_cnt <= 16'(PRESENT_CYC);
      low_cnt <= 16'h0;
    end else begin
      line_q <= share_clk_i;
      gap_cnt <= line_fall ? 16'h0 : (present ? gap_cnt + 16'h1 : gap_cnt);
      low_cnt <= share_clk_i ? 16'h0 : (held_now ? low_cnt : low_cnt + 16'h1);
    end
  end
  // ==========================================================
  // outputs and held-low / release events
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      share_clk_oe_o <= 1'b0;
      base_tick_o <= 1'b0;
      held <= 1'b0;
      chan_off_o <= 1'b0;
      start_seq_o <= 1'b0;
    end else begin
      share_clk_oe_o <= own_low | vin_hold;
      base_tick_o <= present ? line_fall : div_wrap;
      chan_off_o <= held_now & ~held;
      start_seq_o <= held & share_clk_i;
      held <= held_now | (held & ~share_clk_i);
    end
  end
  // ==========================================================
  // checks
  a_vin_hold_low: assert property (@(posedge clock_i) disable iff (rst_i)
    vin_hold |=> share_clk_oe_o) else $error("line not held low on low vin");
  a_release_start: assert property (@(posedge clock_i) disable iff (rst_i)
    held && share_clk_i |=> start_seq_o ##1 !start_seq_o)
    else $error("no single start pulse after release");
endmodule

// [core/wdpg_top.sv]
// watchdog, power-good output and shared clock supervisor top
`timescale 1ns/100ps
module wdpg_top
  import wdpg_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire wdpg_pkg::wdpg_cmd_s cmd_i,            // command port request
  output logic [15:0] cmd_rdata_o,                  // read word
  output logic cmd_ack_o,                           // request taken
  input wire logic vin_share_enable_i,              // global config bit
  input wire logic fast_deassert_select_i,          // global config bit
  input wire logic vin_ok_i,                        // input voltage adequate
  input wire logic [3:0] chan_good_fast_i,          // above undervoltage limit
  input wire logic [3:0] chan_good_polled_i,        // polled good-off result
  input wire logic kick_input_i,                    // watchdog kick pin
  input wire logic alert_clear_i,                   // clear-faults pulse
  input wire logic share_clk_i,                     // shared clock line level
  output logic share_clk_o,                         // drive value, always low
  output logic share_clk_oe_o,                      // pull line low
  output logic chan_off_o,                          // disable all channels
  output logic start_seq_o,                         // begin start sequence
  output logic power_good_o,                        // power-good output
  output logic alert_out_n_o                        // alert, active low
);
  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    PG_LOW = 3'b001,
    PG_DELAY = 3'b010,
    PG_HIGH = 3'b100
  } wdpg_pg_e;
  typedef enum logic [3:0] {
    WD_OFF = 4'b0001,
    WD_ARM = 4'b0010,
    WD_FIRST = 4'b0100,
    WD_NEXT = 4'b1000
  } wdpg_wd_e;
  // ==========================================================
  // registers and state
  logic [15:0] pg_source;     // selected sources
  logic [15:0] pg_delay;      // raw delay word
  logic [15:0] wd_first;      // raw first interval
  logic [15:0] wd_next;       // raw subsequent interval
  wdpg_pg_e pg_state;         // power-good sequencer
  wdpg_pg_e next_pg_state;
  wdpg_wd_e wd_state;         // watchdog sequencer
  wdpg_wd_e next_wd_state;
  logic [4:0] pg_pre;         // base ticks within one 200 us step
  logic [15:0] pg_steps;      // elapsed delay steps
  logic [9:0] wd_div;         // internal 10 us divider
  logic [23:0] wd_cnt;        // elapsed watchdog ticks
  logic wd_expire;            // one-cycle expiry pulse
  logic kick_q;               // previous kick level
  logic base_tick;            // shared-clock time base
  logic [15:0] delay_steps;   // effective delay
  logic [15:0] first_steps;   // effective first interval
  logic [15:0] next_steps;    // effective subsequent interval
  // ==========================================================
  // decode
  wire wr_src = cmd_i.wr & (cmd_i.code == CMD_PG_SOURCE);
  wire wr_dly = cmd_i.wr & (cmd_i.code == CMD_PG_DELAY);
  wire wr_first = cmd_i.wr & (cmd_i.code == CMD_WD_FIRST);
  wire wr_next = cmd_i.wr & (cmd_i.code == CMD_WD_NEXT);
  wire wd_gate = pg_source[PG_SRC_WDOG_BIT];
  wire [3:0] chan_sel = pg_source[3:0];
  // ==========================================================
  // read mux, unmapped codes read zero
  wire [15:0] rd_word =
    (cmd_i.code == CMD_PG_SOURCE) ? (pg_source & PG_SOURCE_MASK) :
    (cmd_i.code == CMD_PG_DELAY) ? pg_delay :
    (cmd_i.code == CMD_WD_FIRST) ? wd_first :
    (cmd_i.code == CMD_WD_NEXT) ? wd_next : 16'h0000;
  // ==========================================================
  // power-good condition
  wire [3:0] chan_good = fast_deassert_select_i ? chan_good_fast_i
                                                : chan_good_polled_i;
  wire chan_ok = &(chan_good | ~chan_sel);
  wire wd_ok = ~(wd_gate & wd_expire);
  wire pg_cond = chan_ok & wd_ok;
  wire pg_step = base_tick & (pg_pre == 5'(PG_STEP_TICKS - 1));
  wire delay_done = pg_steps >= delay_steps;
  // ==========================================================
  // watchdog controls
  wire wd_en = (wd_first[L11_MAN_MSB:0] != 11'h0)
             & (wd_next[L11_MAN_MSB:0] != 11'h0);
  wire kick_rise = kick_input_i & ~kick_q;
  wire wd_restart = kick_rise
                  | (wr_next & (cmd_i.wdata[L11_MAN_MSB:0] != 11'h0));
  wire wd_tick = wd_div == 10'(WD_TICK_CYC - 1);
  wire [23:0] wd_limit = (wd_state == WD_FIRST)
                       ? 24'(first_steps) * 24'(FIRST_TICKS)
                       : 24'(next_steps);
  wire wd_timeout = wd_tick & (wd_cnt + 24'h1 >= wd_limit);
  wire wd_run = (wd_state == WD_FIRST) | (wd_state == WD_NEXT);
  // ==========================================================
  // l11 converters
  wdpg_l11_steps #(.SCALE(PG_SCALE), .MAX_STEPS(PG_MAX_STEPS)) u_dly (
    .l11_i(pg_delay),
    .steps_o(delay_steps)
  );
  wdpg_l11_steps #(.SCALE(FIRST_SCALE), .MAX_STEPS(FIRST_MAX_STEPS)) u_first (
    .l11_i(wd_first),
    .steps_o(first_steps)
  );
  wdpg_l11_steps #(.SCALE(NEXT_SCALE), .MAX_STEPS(NEXT_MAX_STEPS)) u_next (
    .l11_i(wd_next),
    .steps_o(next_steps)
  );
  // ==========================================================
  // shared clock unit
  wdpg_share_clk u_share (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .share_clk_i(share_clk_i),
    .vin_share_i(vin_share_enable_i),
    .vin_ok_i(vin_ok_i),
    .share_clk_oe_o(share_clk_oe_o),
    .base_tick_o(base_tick),
    .chan_off_o(chan_off_o),
    .start_seq_o(start_seq_o)
  );
  // ==========================================================
  // register file and command answer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pg_source <= RST_PG_SOURCE;
      pg_delay <= RST_PG_DELAY;
      wd_first <= RST_WD_INTERVAL;
      wd_next <= RST_WD_INTERVAL;
      cmd_rdata_o <= 16'h0000;
      cmd_ack_o <= 1'b0;
      share_clk_o <= 1'b0;
    end else begin
      if (wr_src) pg_source <= cmd_i.wdata & PG_SOURCE_MASK;
      if (wr_dly) pg_delay <= cmd_i.wdata;
      if (wr_first) wd_first <= cmd_i.wdata;
      if (wr_next) wd_next <= cmd_i.wdata;
      cmd_rdata_o <= cmd_i.rd ? rd_word : 16'h0000;
      cmd_ack_o <= cmd_i.rd | cmd_i.wr;
      share_clk_o <= 1'b0;
    end
  end
  // ==========================================================
  // power-good sequencer next state
  always_comb begin
    next_pg_state = pg_state;
    case (pg_state)
      PG_LOW: begin
        if (pg_cond) next_pg_state = PG_DELAY;
      end
      PG_DELAY: begin
        if (!pg_cond) next_pg_state = PG_LOW;
        else if (delay_done) next_pg_state = PG_HIGH;
      end
      PG_HIGH: begin
        if (!pg_cond) next_pg_state = PG_LOW;
      end
      default: next_pg_state = PG_LOW;
    endcase
  end
  // ==========================================================
  // power-good state, delay counting, output
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pg_state <= PG_LOW;
      pg_pre <= 5'h0;
      pg_steps <= 16'h0;
      power_good_o <= 1'b0;
    end else begin
      pg_state <= next_pg_state;
      power_good_o <= next_pg_state == PG_HIGH;
      if (pg_state != PG_DELAY) begin
        pg_pre <= 5'h0;
        pg_steps <= 16'h0;
      end else if (base_tick) begin
        pg_pre <= pg_step ? 5'h0 : pg_pre + 5'h1;
        if (pg_step && !delay_done) pg_steps <= pg_steps + 16'h1;
      end
    end
  end
  // ==========================================================
  // watchdog sequencer next state
  always_comb begin
    next_wd_state = wd_state;
    case (wd_state)
      WD_OFF: begin
        if (wd_en) next_wd_state = wd_gate ? WD_ARM : WD_FIRST;
      end
      WD_ARM: begin
        if (!wd_en) next_wd_state = WD_OFF;
        // wait out the expiry pulse so the first interval starts after power good returns
        else if (pg_state == PG_HIGH && !wd_expire) next_wd_state = WD_FIRST;
      end
      WD_FIRST, WD_NEXT: begin
        if (!wd_en) next_wd_state = WD_OFF;
        else if (wd_restart) next_wd_state = WD_NEXT;
        else if (wd_timeout) next_wd_state = wd_gate ? WD_ARM : WD_NEXT;
      end
      default: next_wd_state = WD_OFF;
    endcase
  end
  // ==========================================================
  // watchdog timer, expiry and alert
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wd_state <= WD_OFF;
      wd_div <= 10'h0;
      wd_cnt <= 24'h0;
      wd_expire <= 1'b0;
      kick_q <= 1'b0;
      alert_out_n_o <= 1'b1;
    end else begin
      wd_state <= next_wd_state;
      kick_q <= kick_input_i;
      wd_div <= wd_tick ? 10'h0 : wd_div + 10'h1;
      wd_expire <= wd_run & wd_en & ~wd_restart & wd_timeout;
      if (!wd_run || next_wd_state != wd_state || wd_restart || wd_timeout) begin
        wd_cnt <= 24'h0;
      end else if (wd_tick) begin
        wd_cnt <= wd_cnt + 24'h1;
      end
      // set wins over a simultaneous clear
      if (wd_expire) alert_out_n_o <= 1'b0;
      else if (alert_clear_i) alert_out_n_o <= 1'b1;
    end
  end
  // ==========================================================
  // checks
  sequence s_wr_delay;
    cmd_i.wr && cmd_i.code == CMD_PG_DELAY;
  endsequence
  sequence s_rd_delay;
    cmd_i.rd && !cmd_i.wr && cmd_i.code == CMD_PG_DELAY;
  endsequence
  // no further delay write between the write and the read
  sequence s_idle_delay;
    !(cmd_i.wr && cmd_i.code == CMD_PG_DELAY);
  endsequence
  a_delay_readback: assert property (@(posedge clock_i) disable iff (rst_i)
    s_wr_delay ##1 s_idle_delay ##1 s_rd_delay |=> cmd_rdata_o == $past(cmd_i.wdata, 3))
    else $error("delay register not read back as written");
  a_reserved_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_i.rd && cmd_i.code == CMD_PG_SOURCE |=> cmd_rdata_o[15:9] == 7'h0
    && cmd_rdata_o[7:4] == 4'h0) else $error("reserved source bits not zero");
  a_pg_and_drop: assert property (@(posedge clock_i) disable iff (rst_i)
    power_good_o && !chan_ok |=> !power_good_o)
    else $error("power good kept with a selected channel bad");
  a_pg_delay_wait: assert property (@(posedge clock_i) disable iff (rst_i)
    pg_state == PG_DELAY && !delay_done |=> !power_good_o)
    else $error("power good asserted before delay elapsed");
  a_expire_alert: assert property (@(posedge clock_i) disable iff (rst_i)
    wd_expire |=> !alert_out_n_o) else $error("expiry did not raise alert");
  a_gate_drop: assert property (@(posedge clock_i) disable iff (rst_i)
    wd_expire && wd_gate && power_good_o |=> !power_good_o)
    else $error("gated expiry did not drop power good");
  a_kick_restart: assert property (@(posedge clock_i) disable iff (rst_i)
    wd_run && wd_en && kick_rise |=> wd_cnt == 24'h0 && !wd_expire)
    else $error("kick edge did not restart watchdog");
  a_zero_disable: assert property (@(posedge clock_i) disable iff (rst_i)
    !wd_en |=> wd_state == WD_OFF ##1 !wd_expire)
    else $error("zero interval did not stop watchdog");
endmodule

// [tb/wdpg_peer.sv]
// peer power manager sharing the open-drain clock line
`timescale 1ns/100ps
module wdpg_peer #(
  parameter int PERIOD = 800,
  parameter int LOW = 300
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic run_i,   // own clock runs
  input wire logic hold_i,  // own input voltage too low
  input wire logic line_i,  // resolved line level
  output logic oe_o         // pull line low
);
  int cnt;       // own divider
  logic line_q;  // line one cycle ago
  // ==========================================
  // divider, restarted by any line fall
  always_ff @(posedge clock_i) begin
    line_q <= line_i;
    if (rst_i || (line_q && !line_i) || cnt == PERIOD - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // low phase (first LOW cycles) of own clock, or held low while unpowered
  assign oe_o = hold_i || (run_i && cnt < LOW);
endmodule

// [tb/wdpg_top_tb_top.sv]
// self-checking bench of the watchdog and power-good supervisor
`timescale 1ns/100ps
module wdpg_top_tb_top;
  import wdpg_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  wdpg_cmd_s cmd_i = '0;
  logic vin_share = 1'b0, fast_sel = 1'b0, vin_ok = 1'b1, kick = 1'b0, clr = 1'b0;
  logic [3:0] good_fast = '0, good_poll = '0;
  logic peer_run = 1'b0, peer_hold = 1'b0;
  logic [15:0] rdata;
  logic ack, drv, oe, peer_oe, chan_off, start_seq, pg, alert_n;
  wire line = ~(oe | peer_oe);  // wired-or with pull-up
  int num_errors = 0;
  int comparisons = 0;
  int mdl[int];  // register model by command code
  int offs = 0;  // channel-off pulses seen
  int starts = 0;  // start pulses seen
  int s0;
  // ==========================================
  // clock, design and peer
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    offs += (chan_off === 1'b1);
    starts += (start_seq === 1'b1);
  end
  wdpg_top u_dut (.clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd_i), .cmd_rdata_o(rdata),
    .cmd_ack_o(ack), .vin_share_enable_i(vin_share), .fast_deassert_select_i(fast_sel),
    .vin_ok_i(vin_ok), .chan_good_fast_i(good_fast), .chan_good_polled_i(good_poll),
    .kick_input_i(kick), .alert_clear_i(clr), .share_clk_i(line), .share_clk_o(drv),
    .share_clk_oe_o(oe), .chan_off_o(chan_off), .start_seq_o(start_seq),
    .power_good_o(pg), .alert_out_n_o(alert_n));
  wdpg_peer #(.PERIOD(800), .LOW(300)) u_peer (.clock_i(clock_i), .rst_i(rst_i),
    .run_i(peer_run), .hold_i(peer_hold), .line_i(line), .oe_o(peer_oe));
  // ==========================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim, input string msg);
    int i;
    for (i = 0; i < lim && s !== v; i++) begin
      @(posedge clock_i);
      #1;
    end
    chk(s, v, msg);
  endtask
  // one register request, answer checked against the model
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clock_i);
    cmd_i <= '{wr: w, rd: !w, code: c, wdata: d};
    @(posedge clock_i);
    cmd_i <= '0;
    if (w && c == CMD_PG_SOURCE) mdl[c] = d & PG_SOURCE_MASK;
    else if (w && mdl.exists(c)) mdl[c] = d;
    #1;
    chk(ack, 1'b1, "ack");
    if (!w) chk(rdata, mdl.exists(c) ? 16'(mdl[c]) : 16'h0, "read word");
  endtask
  function automatic logic exp_pg();
    logic [3:0] g;
    int m;
    g = fast_sel ? good_fast : good_poll;
    m = mdl[CMD_PG_SOURCE];
    return &(g | ~m[3:0]);
  endfunction
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================
  // hang guard
  initial begin
    #1000000;
    num_errors++;
    $display("FAIL %0t run did not complete", $time);
    close_out();
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h3944331b));
    mdl[CMD_PG_SOURCE] = 16'h0000;
    mdl[CMD_PG_DELAY] = 16'heb20;
    mdl[CMD_WD_FIRST] = 16'h8000;
    mdl[CMD_WD_NEXT] = 16'h8000;
    cyc(3);
    rst_i <= 1'b0;
    foreach (mdl[k]) xfer(1'b0, 8'(k), 16'h0);
    xfer(1'b0, 8'h5a, 16'h0);
    chk(drv, 1'b0, "line drive value");
    xfer(1'b1, CMD_PG_SOURCE, 16'hffff);
    xfer(1'b0, CMD_PG_SOURCE, 16'h0);
    xfer(1'b1, CMD_PG_DELAY, 16'($urandom));
    xfer(1'b0, CMD_PG_DELAY, 16'h0);
    xfer(1'b1, CMD_PG_DELAY, 16'h0000);
    // random selections with zero delay
    for (int i = 0; i < 12; i++) begin
      @(posedge clock_i);
      good_fast <= 4'($urandom);
      good_poll <= 4'($urandom);
      fast_sel <= 1'($urandom);
      xfer(1'b1, CMD_PG_SOURCE, (i == 0) ? 16'h0100 : 16'($urandom));
      cyc(6);
      #1;
      chk(pg, exp_pg(), "power good");
    end
    // delay of one step, 20 falls of the peer's faster line (160 us)
    xfer(1'b1, CMD_PG_SOURCE, 16'h0001);
    @(posedge clock_i);
    fast_sel <= 1'b1;
    good_fast <= 4'h0;
    peer_run <= 1'b1;
    xfer(1'b1, CMD_PG_DELAY, 16'hf001);
    cyc(3000);
    // skip a low phase already under way, then stop at the next line fall
    while (peer_oe === 1'b1) begin
      @(posedge clock_i);
      #1;
    end
    do begin
      @(posedge clock_i);
      #1;
    end while (peer_oe !== 1'b1);
    cyc(3);
    #1;
    chk(oe, 1'b1, "follows line fall");
    cyc(557);
    #1;
    chk(oe, 1'b0, "own low half after fall");
    @(posedge clock_i);
    good_fast <= 4'h1;
    cyc(14500);
    #1;
    chk(pg, 1'b0, "delay not yet over");
    wait_for(pg, 1'b1, 3000, "delay over");
    // watchdog: first interval rounds to zero, next is 6 ticks
    @(posedge clock_i);
    peer_run <= 1'b0;
    xfer(1'b1, CMD_PG_DELAY, 16'h0000);
    xfer(1'b1, CMD_WD_NEXT, 16'hd802);
    xfer(1'b1, CMD_WD_FIRST, 16'hf001);
    wait_for(alert_n, 1'b0, 1200, "first expiry");
    chk(pg, 1'b1, "ungated power good");
    @(posedge clock_i);
    clr <= 1'b1;
    kick <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_i);
      kick <= !kick;
      if (i % 2 == 1) xfer(1'b1, CMD_WD_NEXT, 16'hd802);
      cyc(2000);
    end
    cyc(2500);
    #1;
    chk(alert_n, 1'b1, "kept alive");
    wait_for(alert_n, 1'b0, 2000, "next expiry");
    // gated watchdog pulls power good down and back
    xfer(1'b1, CMD_WD_FIRST, 16'hf001);
    xfer(1'b1, CMD_PG_SOURCE, 16'h0100);
    wait_for(pg, 1'b0, 7000, "gated expiry drop");
    wait_for(pg, 1'b1, 10, "reassert after delay");
    xfer(1'b1, CMD_WD_NEXT, 16'h0000);
    @(posedge clock_i);
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    cyc(7000);
    #1;
    chk(pg, 1'b1, "disabled keeps good");
    chk(alert_n, 1'b1, "disabled no alert");
    // input voltage sharing: peer recovers last
    chk(offs, 0, "no sharing no disable");
    // start the hold in a high phase so the low count begins at zero
    do begin
      @(posedge clock_i);
      #1;
    end while (line !== 1'b1);
    @(posedge clock_i);
    vin_share <= 1'b1;
    vin_ok <= 1'b0;
    peer_hold <= 1'b1;
    cyc(1900);
    #1;
    chk(oe, 1'b1, "held low while unpowered");
    chk(offs, 0, "deglitch");
    wait_for(chan_off, 1'b1, 400, "channels off");
    @(posedge clock_i);
    vin_ok <= 1'b1;
    s0 = starts;
    cyc(1500);
    chk(starts, s0, "line still held");
    @(posedge clock_i);
    peer_hold <= 1'b0;
    wait_for(start_seq, 1'b1, 700, "start on release");
    close_out();
  end
endmodule
